/* design/ccp_clock_control.sv */
// core clock source, gate, pll control register and lock tracking
// assumes control-port framing and strobes synchronous to clk_i
//
// Summary of operation
// [R1] bit 3 picks master clock or pll
// [R2] two-bit ratio: 256/512/768/1024 times base rate
// [R3] core clock stopped until gate bit set
// [R4] pll source forces ratio field to 1024
// [R5] core clock held off during lock acquisition; the code holds it off only while the pll source is selected
// [R6] only clock and pll registers reachable then
// [R7] host waits for gate and lock first
// [R8] host: disable, rewrite, enable, poll, gate
// [R9] pll register updated by complete six-byte write
// [R10] bits 47:32 denominator, reset 253
// [R11] bits 31:16 numerator, reset 12
// [R12] bits 14:11 integer part, reset 2
// [R13] bits 10:9 reference divider 1 to 4
// [R14] bit 8 mode; integer ignores fraction
// [R15] fractional multiplies by int plus num/den
// [R16] bit 1 read-only lock indicator
// [R17] bit 0 enables the pll
// [R18] pll output fixed at 1024 times base
// [R19] rate fields divide base by listed divisors
// [R20] host keeps the three rates equal
// [R21] host adjusts processor rate for slow clock
// [R22] lock cleared on disable or new config
`timescale 1ns/1ps
module ccp_clock_control
	import ccp_pkg::*;
#(
	parameter int LOCK_CYC = CCP_LOCK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cp_start_i,
	input wire logic [15:0] cp_addr_i,
	input wire logic cp_wr_i,
	input wire logic [7:0] cp_wdata_i,
	input wire logic cp_rd_i,
	output logic [7:0] cp_rdata_o,
	output logic cp_rvalid_o,
	output logic core_clk_run_o,
	output logic core_clock_source_select_o,
	output logic [1:0] input_rate_ratio_o,
	output logic pll_turn_on_o,
	output logic pll_fractional_o,
	output logic [1:0] pll_ref_div_o,
	output logic [3:0] pll_int_o,
	output logic [15:0] pll_num_o,
	output logic [15:0] pll_den_o,
	output logic [3:0] conv_rate_half_o,
	output logic [3:0] proc_rate_half_o,
	output logic [3:0] sport_rate_half_o
);
	logic [15:0] addr_reg;
	logic [15:0] start_addr_reg;
	logic [2:0] pll_cnt_reg;
	logic [39:0] pll_shadow_reg;
	logic src_reg;
	logic [1:0] ratio_reg;
	logic gate_reg;
	logic [15:0] den_reg;
	logic [15:0] num_reg;
	logic [3:0] int_reg;
	logic [1:0] div_reg;
	logic mode_reg;
	logic en_reg;
	logic [7:0] conv_reg;
	logic [7:0] proc_reg;
	logic [7:0] sport_reg;
	ccp_pll_state_t pll_state_reg;
	ccp_pll_state_t pll_state_next;
	logic [23:0] lock_cnt_reg;
	logic locked;
	logic core_run;
	logic pll_commit;
	logic [47:0] pll_full;
	logic [47:0] pll_view;
	logic [7:0] rd_byte;
	logic [15:0] pll_off;

	// divisor times two, so 1.5 and 0.5 stay integral; spare codes act as /1
	function automatic logic [3:0] rate_half(input logic [3:0] code);
		unique case (code)
			4'h1: rate_half = 4'hc;
			4'h2: rate_half = 4'h8;
			4'h3: rate_half = 4'h6;
			4'h4: rate_half = 4'h4;
			4'h5: rate_half = 4'h3;
			4'h6: rate_half = 4'h1;
			default: rate_half = 4'h2;
		endcase
	endfunction

	assign locked = (pll_state_reg == CCP_PLL_LOCKED);
	// core runs only when gated on and, on the pll path, locked
	assign core_run = gate_reg && (!src_reg || locked); // [R3] [R5]
	assign pll_off = addr_reg - CCP_ADDR_PLL_CTRL;
	assign pll_full = {pll_shadow_reg, cp_wdata_i};
	// commit only on the sixth byte of a burst that began at the pll address
	assign pll_commit = cp_wr_i && (start_addr_reg == CCP_ADDR_PLL_CTRL)
		&& (pll_cnt_reg == CCP_PLL_BYTES - 3'h1); // [R9]

	// control-port address tracking; bursts auto-increment
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_reg <= 16'h0000;
			start_addr_reg <= 16'h0000;
			pll_cnt_reg <= 3'h0;
			pll_shadow_reg <= 40'h00_0000_0000;
		end else if (ce_i) begin
			if (cp_start_i) begin
				addr_reg <= cp_addr_i;
				start_addr_reg <= cp_addr_i;
				pll_cnt_reg <= 3'h0;
			end else if (cp_wr_i || cp_rd_i) begin
				addr_reg <= addr_reg + 16'h0001;
				if (cp_wr_i && pll_cnt_reg < CCP_PLL_BYTES) begin
					pll_cnt_reg <= pll_cnt_reg + 3'h1;
					pll_shadow_reg <= {pll_shadow_reg[31:0], cp_wdata_i};
				end
			end
		end
	end

	// clock control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_reg <= 1'b0;
			ratio_reg <= CCP_RATIO_RST;
			gate_reg <= 1'b0;
		end else if (ce_i && cp_wr_i && !cp_start_i
			&& addr_reg == CCP_ADDR_CLK_CTRL) begin
			src_reg <= cp_wdata_i[CCP_SRC_BIT]; // [R1]
			gate_reg <= cp_wdata_i[CCP_GATE_BIT]; // [R3]
			if (cp_wdata_i[CCP_SRC_BIT])
				ratio_reg <= CCP_RATIO_PLL; // [R4] [R18]
			else
				ratio_reg <= cp_wdata_i[CCP_RATIO_LSB +: 2]; // [R2]
		end
	end

	// pll control register, loaded whole from one burst
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			den_reg <= CCP_DEN_RST;
			num_reg <= CCP_NUM_RST;
			int_reg <= CCP_INT_RST;
			div_reg <= CCP_DIV_RST;
			mode_reg <= 1'b0;
			en_reg <= 1'b0;
		end else if (ce_i && pll_commit && !cp_start_i) begin
			den_reg <= pll_full[CCP_DEN_LSB +: 16]; // [R10]
			num_reg <= pll_full[CCP_NUM_LSB +: 16]; // [R11]
			int_reg <= pll_full[CCP_INT_LSB +: 4]; // [R12]
			div_reg <= pll_full[CCP_DIV_LSB +: 2]; // [R13]
			mode_reg <= pll_full[CCP_MODE_BIT]; // [R14]
			en_reg <= pll_full[CCP_EN_BIT]; // [R17]
		end
	end

	// sampling-rate registers need the core clock running
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_reg <= CCP_RATE_RST;
			proc_reg <= CCP_RATE_RST;
			sport_reg <= CCP_RATE_RST;
		end else if (ce_i && cp_wr_i && !cp_start_i && core_run) begin // [R6]
			if (addr_reg == CCP_ADDR_CONV_CTRL0)
				conv_reg <= cp_wdata_i;
			if (addr_reg == CCP_ADDR_PROC_RATE)
				proc_reg <= cp_wdata_i;
			if (addr_reg == CCP_ADDR_SPORT_RATE)
				sport_reg <= cp_wdata_i;
		end
	end

	// lock tracker: a fresh config restarts acquisition from zero, except mid-acquisition where the count runs on
	always_comb begin
		pll_state_next = pll_state_reg;
		unique case (pll_state_reg)
			CCP_PLL_OFF: begin
				if (en_reg)
					pll_state_next = CCP_PLL_ACQ;
			end
			CCP_PLL_ACQ: begin
				if (lock_cnt_reg >= 24'(LOCK_CYC - 1))
					pll_state_next = CCP_PLL_LOCKED;
			end
			CCP_PLL_LOCKED: pll_state_next = CCP_PLL_LOCKED;
			default: pll_state_next = CCP_PLL_OFF;
		endcase
		if (!en_reg)
			pll_state_next = CCP_PLL_OFF; // [R22]
		else if (pll_commit && !cp_start_i)
			pll_state_next = CCP_PLL_ACQ; // [R22]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_state_reg <= CCP_PLL_OFF;
			lock_cnt_reg <= 24'h00_0000;
		end else if (ce_i) begin
			pll_state_reg <= pll_state_next; // [R16]
			if (pll_state_next == CCP_PLL_ACQ && pll_state_reg == CCP_PLL_ACQ)
				lock_cnt_reg <= lock_cnt_reg + 24'h00_0001;
			else
				lock_cnt_reg <= 24'h00_0000;
		end
	end

	// readback; reserved bits read zero, gated registers read zero too
	assign pll_view = {den_reg, num_reg, 1'b0, int_reg, div_reg, mode_reg,
		6'h00, locked, en_reg};

	always_comb begin
		rd_byte = 8'h00;
		if (addr_reg == CCP_ADDR_CLK_CTRL)
			rd_byte = {4'h0, src_reg, ratio_reg, gate_reg};
		else if (pll_off < 16'(CCP_PLL_BYTES))
			rd_byte = pll_view[8'(47 - 8 * int'(pll_off[2:0])) -: 8];
		else if (core_run) begin // [R6]
			if (addr_reg == CCP_ADDR_CONV_CTRL0)
				rd_byte = conv_reg;
			else if (addr_reg == CCP_ADDR_PROC_RATE)
				rd_byte = proc_reg;
			else if (addr_reg == CCP_ADDR_SPORT_RATE)
				rd_byte = sport_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cp_rdata_o <= 8'h00;
			cp_rvalid_o <= 1'b0;
		end else if (ce_i) begin
			cp_rvalid_o <= cp_rd_i && !cp_start_i;
			if (cp_rd_i && !cp_start_i)
				cp_rdata_o <= rd_byte;
		end
	end

	// registered views to the clock tree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_clk_run_o <= 1'b0;
			core_clock_source_select_o <= 1'b0;
			input_rate_ratio_o <= CCP_RATIO_RST;
			pll_turn_on_o <= 1'b0;
			pll_fractional_o <= 1'b0;
			pll_ref_div_o <= CCP_DIV_RST;
			pll_int_o <= CCP_INT_RST;
			pll_num_o <= 16'h0000;
			pll_den_o <= CCP_DEN_RST;
			conv_rate_half_o <= 4'h2;
			proc_rate_half_o <= 4'h2;
			sport_rate_half_o <= 4'h2;
		end else if (ce_i) begin
			core_clk_run_o <= core_run; // [R5]
			core_clock_source_select_o <= src_reg; // [R1]
			input_rate_ratio_o <= ratio_reg; // [R18]
			pll_turn_on_o <= en_reg;
			pll_fractional_o <= mode_reg; // [R15]
			pll_ref_div_o <= div_reg;
			pll_int_o <= int_reg;
			// integer mode presents no fractional part
			pll_num_o <= mode_reg ? num_reg : 16'h0000; // [R14]
			pll_den_o <= den_reg;
			conv_rate_half_o <= rate_half({1'b0, conv_reg[2:0]}); // [R19]
			proc_rate_half_o <= rate_half(proc_reg[3:0]); // [R19]
			sport_rate_half_o <= rate_half({1'b0, sport_reg[2:0]}); // [R19]
		end
	end
endmodule

/* inc/ccp_pkg.sv */
// constants for the core clock and pll control block
// assumes a 200 MHz system clock and a byte-wide control port
package ccp_pkg;
	// register addresses on the control port
	localparam logic [15:0] CCP_ADDR_CLK_CTRL = 16'h4000;
	localparam logic [15:0] CCP_ADDR_PLL_CTRL = 16'h4002;
	localparam logic [15:0] CCP_ADDR_CONV_CTRL0 = 16'h4017;
	localparam logic [15:0] CCP_ADDR_PROC_RATE = 16'h40eb;
	localparam logic [15:0] CCP_ADDR_SPORT_RATE = 16'h40f8;
	localparam logic [2:0] CCP_PLL_BYTES = 3'h6;

	// clock control field positions
	localparam int CCP_SRC_BIT = 3;
	localparam int CCP_RATIO_LSB = 1;
	localparam int CCP_GATE_BIT = 0;

	// pll control field positions
	localparam int CCP_DEN_LSB = 32;
	localparam int CCP_NUM_LSB = 16;
	localparam int CCP_INT_LSB = 11;
	localparam int CCP_DIV_LSB = 9;
	localparam int CCP_MODE_BIT = 8;
	localparam int CCP_LOCK_BIT = 1;
	localparam int CCP_EN_BIT = 0;

	// reset values and the forced pll ratio
	localparam logic [1:0] CCP_RATIO_RST = 2'h0;
	localparam logic [1:0] CCP_RATIO_PLL = 2'h3;
	localparam logic [15:0] CCP_DEN_RST = 16'h00fd;
	localparam logic [15:0] CCP_NUM_RST = 16'h000c;
	localparam logic [3:0] CCP_INT_RST = 4'h2;
	localparam logic [1:0] CCP_DIV_RST = 2'h0;
	localparam logic [7:0] CCP_RATE_RST = 8'h00;

	// lock acquisition time
	localparam int CCP_CLK_PERIOD_NS = 5;
	localparam int CCP_LOCK_TIME_NS = 2_960_000;
	localparam int CCP_LOCK_CYCLES = CCP_LOCK_TIME_NS / CCP_CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		CCP_PLL_OFF = 2'b00,
		CCP_PLL_ACQ = 2'b01,
		CCP_PLL_LOCKED = 2'b10
	} ccp_pll_state_t;
endpackage

/* verif/ccp_clock_control_properties.sv */
// port checker for the clock control block
// assumes LOCK_CYC matches the bound instance
`timescale 1ns/1ps
module ccp_checker #(parameter int LOCK_CYC = 20) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic cp_start_i,
	input wire logic cp_wr_i,
	input wire logic cp_rd_i,
	input wire logic [7:0] cp_rdata_o,
	input wire logic cp_rvalid_o,
	input wire logic core_clk_run_o,
	input wire logic core_clock_source_select_o,
	input wire logic [1:0] input_rate_ratio_o,
	input wire logic pll_turn_on_o,
	input wire logic pll_fractional_o,
	input wire logic [15:0] pll_num_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a rewrite only restarts later, so a count from enable is an upper bound
	int unsigned on_cnt;
	always_ff @(posedge clk_i)
		on_cnt <= !pll_turn_on_o ? 0 : (on_cnt < 9999 ? on_cnt + 1 : on_cnt);
	rd_answer_a: assert property (cp_rd_i && ce_i && !cp_start_i
		|=> cp_rvalid_o) else $error("read not answered");
	rdata_hold_a: assert property ($changed(cp_rdata_o) |-> cp_rvalid_o)
		else $error("read data moved");
	ratio_forced_a: assert property (core_clock_source_select_o
		|-> input_rate_ratio_o == 2'h3) else $error("ratio not forced");
	lock_wait_a: assert property ($rose(core_clk_run_o) &&
		core_clock_source_select_o |-> on_cnt >= LOCK_CYC - 2)
		else $error("core ran before lock");
	acq_dark_a: assert property ($rose(pll_turn_on_o) &&
		core_clock_source_select_o |-> !core_clk_run_o [*8])
		else $error("core ran while acquiring");
	int_mode_a: assert property (!pll_fractional_o |-> pll_num_o == 0)
		else $error("numerator used in integer mode");
	pll_commit_a: assert property ($changed(pll_turn_on_o)
		|-> $past(cp_wr_i, 2)) else $error("pll changed without write");
	run_cause_a: assert property ($rose(core_clk_run_o) &&
		!core_clock_source_select_o |-> $past(cp_wr_i, 2) || $past(cp_wr_i, 3))
		else $error("core started without write");
	cover property ($rose(core_clk_run_o) && core_clock_source_select_o);
	cover property ($fell(pll_turn_on_o));
	cover property (pll_fractional_o && cp_rvalid_o);
endmodule
bind ccp_clock_control ccp_checker #(.LOCK_CYC(LOCK_CYC)) i_chk (.clk_i,
	.rst_i, .ce_i, .cp_start_i, .cp_wr_i, .cp_rd_i, .cp_rdata_o, .cp_rvalid_o,
	.core_clk_run_o, .core_clock_source_select_o, .input_rate_ratio_o,
	.pll_turn_on_o, .pll_fractional_o, .pll_num_o);

/* verif/ccp_host.sv */
// control-port host model for the clock control block
// assumes callers enter each task just after a rising edge
`timescale 1ns/1ps
module ccp_host (
	input wire logic clk_i,
	output logic cp_start_o,
	output logic [15:0] cp_addr_o,
	output logic cp_wr_o,
	output logic [7:0] cp_wdata_o,
	output logic cp_rd_o
);
	initial begin
		cp_start_o = 1'b0;
		cp_addr_o = 16'h0000;
		cp_wr_o = 1'b0;
		cp_wdata_o = 8'h00;
		cp_rd_o = 1'b0;
	end
	// one start then n back-to-back bytes, msb first, never split
	task automatic wr(input logic [15:0] a, input logic [47:0] v, input int n);
		cp_start_o <= 1'b1;
		cp_addr_o <= a;
		@(posedge clk_i);
		cp_start_o <= 1'b0;
		cp_addr_o <= ~a;
		for (int i = n - 1; i >= 0; i--) begin
			cp_wr_o <= 1'b1;
			cp_wdata_o <= v[8*i +: 8];
			@(posedge clk_i);
		end
		cp_wr_o <= 1'b0;
		// released data must not look like the last byte
		cp_wdata_o <= ~cp_wdata_o;
	endtask
	task automatic rd(input logic [15:0] a);
		cp_start_o <= 1'b1;
		cp_addr_o <= a;
		@(posedge clk_i);
		cp_start_o <= 1'b0;
		cp_addr_o <= ~a;
		cp_rd_o <= 1'b1;
		@(posedge clk_i);
		cp_rd_o <= 1'b0;
	endtask
endmodule

/* verif/testbench.sv */
// self-checking bench for the clock control block
// host model drives the port; reads are scored from a queue
`timescale 1ns/1ps
module testbench;
	import ccp_pkg::*;
	logic clk_i = 0, rst_i = 1, ce_i = 1, cp_start_i, cp_wr_i, cp_rd_i;
	logic cp_rvalid_o, core_clk_run_o, core_clock_source_select_o;
	logic pll_turn_on_o, pll_fractional_o;
	logic [15:0] cp_addr_i, pll_num_o, pll_den_o;
	logic [7:0] cp_wdata_i, cp_rdata_o, exp_q[$];
	logic [1:0] input_rate_ratio_o, pll_ref_div_o;
	logic [3:0] pll_int_o, conv_rate_half_o, proc_rate_half_o, sport_rate_half_o;
	logic [3:0] half_tab[8] = '{4'h2, 4'hc, 4'h8, 4'h6, 4'h4, 4'h3, 4'h1, 4'h2};
	logic [31:0] seed = 32'h2928_8a54;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	int num_errors = 0, num_checks = 0;
	always #2.5 clk_i = ~clk_i;
	ccp_host i_host (.clk_i, .cp_start_o(cp_start_i), .cp_addr_o(cp_addr_i),
		.cp_wr_o(cp_wr_i), .cp_wdata_o(cp_wdata_i), .cp_rd_o(cp_rd_i));
	ccp_clock_control #(.LOCK_CYC(20)) i_dut (.clk_i, .rst_i, .ce_i,
		.cp_start_i, .cp_addr_i, .cp_wr_i, .cp_wdata_i, .cp_rd_i, .cp_rdata_o,
		.cp_rvalid_o, .core_clk_run_o, .core_clock_source_select_o,
		.input_rate_ratio_o, .pll_turn_on_o, .pll_fractional_o, .pll_ref_div_o,
		.pll_int_o, .pll_num_o, .pll_den_o, .conv_rate_half_o, .proc_rate_half_o,
		.sport_rate_half_o);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	always @(posedge clk_i)
		if (cp_rvalid_o === 1'b1 && exp_q.size() > 0)
			chk(cp_rdata_o, exp_q.pop_front());
	task automatic rdx(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.rd(a);
		@(posedge clk_i);
	endtask
	task automatic pll_rd(input logic [47:0] v);
		for (int i = 0; i < 6; i++)
			rdx(CCP_ADDR_PLL_CTRL + 16'(i), v[40-8*i +: 8]);
	endtask
	task automatic wrw(input logic [15:0] a, input logic [7:0] d);
		i_host.wr(a, 48'(d), 1);
		repeat (3) @(posedge clk_i);
	endtask
	task automatic end_of_test();
		num_errors += exp_q.size();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// disable, rewrite, enable, then poll the lock byte under a bound
	task automatic pll_go(input logic [47:0] v);
		i_host.wr(CCP_ADDR_PLL_CTRL, v & ~48'h1, 6);
		i_host.wr(CCP_ADDR_PLL_CTRL, v, 6);
		rdx(16'h4007, v[7:0] & 8'hfd);
		for (int i = 0; i < 60 && cp_rdata_o[1] !== 1'b1; i++) begin
			i_host.rd(16'h4007);
			@(posedge clk_i);
		end
		if (cp_rdata_o[1] !== 1'b1) begin
			num_errors++;
			end_of_test();
		end
	endtask
	initial begin
		logic [7:0] c;
		logic [47:0] v;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rdx(CCP_ADDR_CLK_CTRL, 8'h00);
		pll_rd(48'h00fd_000c_1000);
		wrw(CCP_ADDR_CONV_CTRL0, 8'h05);
		chk(core_clk_run_o, 0);
		for (int r = 0; r < 4; r++) begin
			wrw(CCP_ADDR_CLK_CTRL, 8'(2 * r + 1));
			chk(input_rate_ratio_o, 16'(r));
			chk(core_clk_run_o, 1);
		end
		rdx(CCP_ADDR_CONV_CTRL0, 8'h00);
		for (int k = 0; k < 7; k++) begin
			seed = lfsr(seed);
			c = seed[7:0] % 7;
			i_host.wr(CCP_ADDR_CONV_CTRL0, 48'(k), 1);
			i_host.wr(CCP_ADDR_SPORT_RATE, 48'(6 - k), 1);
			wrw(CCP_ADDR_PROC_RATE, c);
			chk(conv_rate_half_o, half_tab[k]);
			chk(sport_rate_half_o, half_tab[6-k]);
			chk(proc_rate_half_o, half_tab[c]);
		end
		// settle on one common rate before the clock source moves
		i_host.wr(CCP_ADDR_CONV_CTRL0, 48'(c), 1);
		i_host.wr(CCP_ADDR_SPORT_RATE, 48'(c), 1);
		wrw(CCP_ADDR_CLK_CTRL, 8'h08);
		chk(conv_rate_half_o, half_tab[c]);
		chk(sport_rate_half_o, half_tab[c]);
		chk(core_clock_source_select_o, 1);
		chk(input_rate_ratio_o, 3);
		rdx(CCP_ADDR_CLK_CTRL, 8'h0e);
		rdx(CCP_ADDR_PROC_RATE, 8'h00);
		i_host.wr(CCP_ADDR_PLL_CTRL, 48'h007d_000c_2101, 5);
		pll_rd(48'h00fd_000c_1000);
		pll_go(48'h007d_000c_2101);
		wrw(CCP_ADDR_CLK_CTRL, 8'h09);
		chk(core_clk_run_o, 1);
		chk(pll_den_o, 16'h007d);
		chk(pll_num_o, 16'h000c);
		chk(pll_fractional_o, 1);
		rdx(CCP_ADDR_PROC_RATE, c);
		for (int d = 0; d < 4; d++) begin
			v = 48'h007d_000c_0003 | (48'(d + 5) << 11) | (48'(d) << 9);
			pll_go(v);
			repeat (3) @(posedge clk_i);
			chk(pll_ref_div_o, 16'(d));
			chk(pll_int_o, 16'(d + 5));
			chk(pll_num_o, 0);
			chk(pll_fractional_o, 0);
			chk(pll_turn_on_o, 1);
			chk(core_clk_run_o, 1);
		end
		// a frozen block must ignore a write that would stop the core
		ce_i <= 1'b0;
		wrw(CCP_ADDR_CLK_CTRL, 8'h00);
		chk(core_clk_run_o, 1);
		ce_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(core_clk_run_o, 1);
		end_of_test();
	end
endmodule
